// ==== core/pwmdac_top.sv ====
// pulse generator with converter code select and output routing control
`timescale 1ns/1ns
module pwmdac_top (
	// clock and resets
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        cpu_rst,
	// register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// pulse outputs
	output logic             digital_out_pos_pin,
	output logic             digital_out_neg_pin,
	// converter and analog control
	output logic      [13:0] conv_code,
	output logic             amp_from_pulse,
	output logic             conv_to_amp,
	output logic             conv_to_probe,
	output logic             ref_ratiometric,
	output logic             amp_current_mode,
	output logic      [1:0]  amp_gain
);
	////////////////////////////////////////////////////////////////////////
	typedef enum logic {PWMDAC_LOW, PWMDAC_HIGH} pwmdac_phase_e;

	pwmdac_tick_if tk ();

	logic [13:0] code_low_reg, code_low_next, code_high_reg, code_high_next;
	logic [15:0] on_reg, on_next, off_reg, off_next;
	logic [15:0] on_act_reg, on_act_next, off_act_reg, off_act_next;
	logic [15:0] timer_reg, timer_next;
	logic [7:0]  en_reg, en_next, cfg_reg, cfg_next, ctrl_reg, ctrl_next;
	logic [7:0]  route_reg, route_next, rdata_next;
	pwmdac_phase_e phase_reg, phase_next;
	logic [13:0] code_out_next;
	logic        pos_next, pulse_en, conv_en, follow;

	assign pulse_en = en_reg[pwmdac_pkg::BIT_PULSE_EN];
	assign conv_en  = ctrl_reg[pwmdac_pkg::BIT_CONV_EN];
	assign follow   = pulse_en && !conv_en;
	assign tk.run   = pulse_en;

	pwmdac_tick_div #(.DIV(pwmdac_pkg::TICK_DIV)) u_div (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tk      (tk)
	);

	////////////////////////////////////////////////////////////////////////
	// register writes
	always_comb begin
		code_low_next  = code_low_reg;
		code_high_next = code_high_reg;
		on_next        = on_reg;
		off_next       = off_reg;
		en_next        = en_reg;
		cfg_next       = cfg_reg;
		ctrl_next      = ctrl_reg;
		route_next     = route_reg;
		if (cpu_rst) begin
			code_low_next  = pwmdac_pkg::CODE_RESET;
			code_high_next = pwmdac_pkg::CODE_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				pwmdac_pkg::ADDR_CODE_LOW_0:  code_low_next[7:0] = reg_wdata;
				pwmdac_pkg::ADDR_CODE_LOW_1:  code_low_next[13:8] = reg_wdata[5:0];
				pwmdac_pkg::ADDR_CODE_HIGH_0: code_high_next[7:0] = reg_wdata;
				pwmdac_pkg::ADDR_CODE_HIGH_1: code_high_next[13:8] = reg_wdata[5:0];
				default: ;
			endcase
		end
		if (reg_wr) begin
			unique case (reg_addr)
				pwmdac_pkg::ADDR_ON_0:       on_next[7:0] = reg_wdata;
				pwmdac_pkg::ADDR_ON_1:       on_next[15:8] = reg_wdata;
				pwmdac_pkg::ADDR_OFF_0:      off_next[7:0] = reg_wdata;
				pwmdac_pkg::ADDR_OFF_1:      off_next[15:8] = reg_wdata;
				pwmdac_pkg::ADDR_PULSE_EN:   en_next = {7'h00, reg_wdata[0]};
				pwmdac_pkg::ADDR_CONV_CFG:   cfg_next = {4'h0, reg_wdata[3:0]};
				pwmdac_pkg::ADDR_CONV_CTRL:  ctrl_next = {7'h00, reg_wdata[0]};
				pwmdac_pkg::ADDR_ROUTE_CTRL: route_next = {7'h00, reg_wdata[0]};
				default: ;
			endcase
		end
	end

	// read mux
	always_comb begin
		rdata_next = 8'h00;
		unique case (reg_addr)
			pwmdac_pkg::ADDR_CODE_LOW_0:  rdata_next = code_low_reg[7:0];
			pwmdac_pkg::ADDR_CODE_LOW_1:  rdata_next = {2'b00, code_low_reg[13:8]};
			pwmdac_pkg::ADDR_CODE_HIGH_0: rdata_next = code_high_reg[7:0];
			pwmdac_pkg::ADDR_CODE_HIGH_1: rdata_next = {2'b00, code_high_reg[13:8]};
			pwmdac_pkg::ADDR_ON_0:        rdata_next = on_reg[7:0];
			pwmdac_pkg::ADDR_ON_1:        rdata_next = on_reg[15:8];
			pwmdac_pkg::ADDR_OFF_0:       rdata_next = off_reg[7:0];
			pwmdac_pkg::ADDR_OFF_1:       rdata_next = off_reg[15:8];
			pwmdac_pkg::ADDR_PULSE_EN:    rdata_next = en_reg;
			pwmdac_pkg::ADDR_CONV_CFG:    rdata_next = cfg_reg;
			pwmdac_pkg::ADDR_CONV_CTRL:   rdata_next = ctrl_reg;
			pwmdac_pkg::ADDR_ROUTE_CTRL:  rdata_next = route_reg;
			pwmdac_pkg::ADDR_STATUS:      rdata_next = {7'h00, phase_reg == PWMDAC_HIGH};
			default:                      rdata_next = 8'h00;
		endcase
		if (!reg_rd) begin
			rdata_next = reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pulse timer: counts ticks within the current phase
	always_comb begin
		timer_next   = timer_reg;
		phase_next   = phase_reg;
		on_act_next  = on_act_reg;
		off_act_next = off_act_reg;
		if (!pulse_en) begin
			timer_next = 16'h0000;
			phase_next = PWMDAC_LOW;
		end else if (tk.tick) begin
			unique case (phase_reg)
				PWMDAC_LOW: begin
					if (timer_reg == 16'h0000 || timer_reg >= off_act_reg) begin
						timer_next   = 16'h0001;
						phase_next   = (on_reg != 16'h0000) ? PWMDAC_HIGH : PWMDAC_LOW;
						on_act_next  = on_reg;
						off_act_next = off_reg;
					end else begin
						timer_next = timer_reg + 16'h0001;
					end
				end
				PWMDAC_HIGH: begin
					if (timer_reg >= on_act_reg) begin
						timer_next = 16'h0001;
						phase_next = (off_act_reg != 16'h0000) ? PWMDAC_LOW : PWMDAC_HIGH;
					end else begin
						timer_next = timer_reg + 16'h0001;
					end
				end
			endcase
		end
	end

	// output selection
	always_comb begin
		pos_next      = (phase_next == PWMDAC_HIGH);
		code_out_next = code_low_reg;
		if (follow && pos_next) begin
			code_out_next = code_high_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			code_low_reg        <= pwmdac_pkg::CODE_RESET;
			code_high_reg       <= pwmdac_pkg::CODE_RESET;
			on_reg              <= pwmdac_pkg::INTERVAL_RESET;
			off_reg             <= pwmdac_pkg::INTERVAL_RESET;
			on_act_reg          <= pwmdac_pkg::INTERVAL_RESET;
			off_act_reg         <= pwmdac_pkg::INTERVAL_RESET;
			timer_reg           <= 16'h0000;
			phase_reg           <= PWMDAC_LOW;
			en_reg              <= 8'h00;
			cfg_reg             <= 8'h00;
			ctrl_reg            <= 8'h00;
			route_reg           <= 8'h00;
			reg_rdata           <= 8'h00;
			digital_out_pos_pin <= 1'b0;
			digital_out_neg_pin <= 1'b1;
			conv_code           <= pwmdac_pkg::CODE_RESET;
			amp_from_pulse      <= 1'b0;
			conv_to_amp         <= 1'b0;
			conv_to_probe       <= 1'b1;
			ref_ratiometric     <= 1'b0;
			amp_current_mode    <= 1'b0;
			amp_gain            <= 2'b00;
		end else begin
			code_low_reg        <= code_low_next;
			code_high_reg       <= code_high_next;
			on_reg              <= on_next;
			off_reg             <= off_next;
			on_act_reg          <= on_act_next;
			off_act_reg         <= off_act_next;
			timer_reg           <= timer_next;
			phase_reg           <= phase_next;
			en_reg              <= en_next;
			cfg_reg             <= cfg_next;
			ctrl_reg            <= ctrl_next;
			route_reg           <= route_next;
			reg_rdata           <= rdata_next;
			digital_out_pos_pin <= pos_next;
			digital_out_neg_pin <= !pos_next;
			conv_code           <= code_out_next;
			amp_from_pulse      <= follow;
			conv_to_amp         <= route_reg[pwmdac_pkg::BIT_ROUTE_AMP];
			conv_to_probe       <= !route_reg[pwmdac_pkg::BIT_ROUTE_AMP];
			ref_ratiometric     <= cfg_reg[pwmdac_pkg::BIT_RATIO];
			amp_current_mode    <= cfg_reg[pwmdac_pkg::BIT_CURRENT];
			amp_gain            <= cfg_reg[pwmdac_pkg::BIT_GAIN_LO +: 2];
		end
	end
endmodule

// ==== core/pwmdac_pkg.sv ====
// package with register map, field positions, reset values and timing counts
package pwmdac_pkg;
	// register byte offsets (8-bit register port)
	localparam logic [7:0] ADDR_CODE_LOW_0  = 8'h2F;
	localparam logic [7:0] ADDR_CODE_LOW_1  = 8'h30;
	localparam logic [7:0] ADDR_CODE_HIGH_0 = 8'h31;
	localparam logic [7:0] ADDR_CODE_HIGH_1 = 8'h32;
	localparam logic [7:0] ADDR_ON_0        = 8'h40;
	localparam logic [7:0] ADDR_ON_1        = 8'h41;
	localparam logic [7:0] ADDR_OFF_0       = 8'h42;
	localparam logic [7:0] ADDR_OFF_1       = 8'h43;
	localparam logic [7:0] ADDR_PULSE_EN    = 8'h44;
	localparam logic [7:0] ADDR_CONV_CFG    = 8'h45;
	localparam logic [7:0] ADDR_CONV_CTRL   = 8'h46;
	localparam logic [7:0] ADDR_ROUTE_CTRL  = 8'h47;
	localparam logic [7:0] ADDR_STATUS      = 8'h48;
	// field positions
	localparam int BIT_PULSE_EN   = 0;
	localparam int BIT_RATIO      = 0;
	localparam int BIT_CURRENT    = 1;
	localparam int BIT_GAIN_LO    = 2;
	localparam int BIT_CONV_EN    = 0;
	localparam int BIT_ROUTE_AMP  = 0;
	// widths and reset values
	localparam int CODE_W = 14;
	localparam int TIMER_W = 16;
	localparam logic [13:0] CODE_RESET = 14'h0000;
	localparam logic [15:0] INTERVAL_RESET = 16'h0001;
	// timing: tick rate derived from system clock
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_HZ = 4_000_000;
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
endpackage

// ==== core/pwmdac_tick_if.sv ====
// interface carrying the tick enable between divider and pulse core
`timescale 1ns/1ns
interface pwmdac_tick_if;
	logic run;
	logic tick;
	modport divider (input run, output tick);
	modport core (output run, input tick);
endinterface

// ==== core/pwmdac_tick_div.sv ====
// divider making a one-cycle 4 MHz tick enable from the system clock
`timescale 1ns/1ns
module pwmdac_tick_div #(
	parameter int DIV = pwmdac_pkg::TICK_DIV
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// tick link
	pwmdac_tick_if.divider  tk
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic       tick_reg;
	logic       tick_next;

	// count up while running, pulse on wrap
	always_comb begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (!tk.run) begin
			cnt_next = 8'h00;
		end else if (cnt_reg == 8'(DIV - 1)) begin
			cnt_next  = 8'h00;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 8'h01;
		end
	end

	// register divider state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg  <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tk.tick = tick_reg;
endmodule

// ==== verif/pwmdac_monitor.sv ====
// checker for the pulse generator register and output behaviour
`timescale 1ns/1ns
module pwmdac_monitor (
	// clock and resets
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        cpu_rst,
	// register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	// pulse and analog control outputs
	input wire logic        digital_out_pos_pin,
	input wire logic        digital_out_neg_pin,
	input wire logic [13:0] conv_code,
	input wire logic        amp_from_pulse,
	input wire logic        conv_to_amp,
	input wire logic        conv_to_probe,
	input wire logic        ref_ratiometric,
	input wire logic        amp_current_mode,
	input wire logic [1:0]  amp_gain
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_pins_complement: assert property (digital_out_neg_pin != digital_out_pos_pin)
		else $error("pulse pins not complementary");
	a_route_complement: assert property (conv_to_probe != conv_to_amp)
		else $error("probe route not inverse of amp route");
	a_route_write: assert property (reg_wr && reg_addr == pwmdac_pkg::ADDR_ROUTE_CTRL
		|-> ##2 conv_to_amp == $past(reg_wdata[0], 2)) else $error("route bit not applied");
	a_cfg_write: assert property (reg_wr && reg_addr == pwmdac_pkg::ADDR_CONV_CFG
		|-> ##2 {amp_gain, amp_current_mode, ref_ratiometric} == $past(reg_wdata[3:0], 2))
		else $error("config fields not applied");
	a_cpu_clear: assert property (cpu_rst [*2] |=> conv_code == 14'h0000)
		else $error("codes not cleared by processor reset");
	a_high_hold: assert property ($rose(digital_out_pos_pin)
		|=> $stable(digital_out_pos_pin) [*8]) else $error("high interval too short");
	a_code_const: assert property ($changed(conv_code) |-> $past(reg_wr, 2)
		|| $past(cpu_rst, 2) || amp_from_pulse || $past(amp_from_pulse))
		else $error("constant level changed without cause");
	a_code_width: assert property (reg_rd && (reg_addr == pwmdac_pkg::ADDR_CODE_LOW_1
		|| reg_addr == pwmdac_pkg::ADDR_CODE_HIGH_1) |=> reg_rdata[7:6] == 2'h0)
		else $error("code upper bits not zero");
endmodule
bind pwmdac_top pwmdac_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .cpu_rst(cpu_rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .digital_out_pos_pin(digital_out_pos_pin),
	.digital_out_neg_pin(digital_out_neg_pin), .conv_code(conv_code),
	.amp_from_pulse(amp_from_pulse), .conv_to_amp(conv_to_amp), .conv_to_probe(conv_to_probe),
	.ref_ratiometric(ref_ratiometric), .amp_current_mode(amp_current_mode), .amp_gain(amp_gain));

// ==== verif/pwmdac_stage_model.sv ====
// output stage model measuring pulse run lengths and the level in each phase
`timescale 1ns/1ns
module pwmdac_stage_model (
	// clock and stage inputs
	input wire logic        clk,
	input wire logic        pulse,
	input wire logic [13:0] code,
	// last completed runs and levels seen
	output int              hi_len,
	output int              lo_len,
	output logic [13:0]     hi_code,
	output logic [13:0]     lo_code
);
	int   run = 0;
	logic last = 1'b0;
	// count cycles per phase; sample the level well inside each run
	always @(posedge clk) begin
		if (pulse != last) begin
			if (last) hi_len <= run;
			else lo_len <= run;
			run <= 1;
		end else run <= run + 1;
		if (run == 10 && pulse) hi_code <= code;
		if (run == 10 && !pulse) lo_code <= code;
		last <= pulse;
	end
endmodule

// ==== verif/tb_pwm_dac_output_select.sv ====
// self-checking bench for pulse timing, code select and routing control
`timescale 1ns/1ns
module tb_pwm_dac_output_select;
	logic        clk, sys_rst, cpu_rst, reg_wr, reg_rd, pos, neg, afp, c2a, c2p, rat, cur;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [1:0]  gain;
	logic [13:0] code, hi_code, lo_code;
	int          hi_len, lo_len, bad_count, samples_checked;
	pwmdac_top uut (.clk(clk), .sys_rst(sys_rst), .cpu_rst(cpu_rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.digital_out_pos_pin(pos), .digital_out_neg_pin(neg), .conv_code(code),
		.amp_from_pulse(afp), .conv_to_amp(c2a), .conv_to_probe(c2p),
		.ref_ratiometric(rat), .amp_current_mode(cur), .amp_gain(gain));
	pwmdac_stage_model stage (.clk(clk), .pulse(pos), .code(code), .hi_len(hi_len),
		.lo_len(lo_len), .hi_code(hi_code), .lo_code(lo_code));
	// compare and count
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// register write and read, entered at a falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		// idle edge so a following write never re-raises the strobe in this step
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd = 1'b1; reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// bounded wait for the pulse pin to reach a level
	task automatic wait_pin(input logic v);
		int n;
		n = 0;
		while (pos !== v && n < 1000) begin
			@(negedge clk);
			n++;
		end
		if (pos !== v) begin
			bad_count++;
			final_report();
		end
		@(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{sys_rst, cpu_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 19'h0_0000};
		bad_count = 0; samples_checked = 0;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		rd(pwmdac_pkg::ADDR_CODE_LOW_0, 8'h00);
		rd(8'h00, 8'h00);
		for (int i = 0; i < 16; i++) begin
			wr(pwmdac_pkg::ADDR_CONV_CFG, 8'(i));
			@(negedge clk);
			chk({gain, cur, rat}, 16'(i));
		end
		for (int i = 0; i < 2; i++) begin
			wr(pwmdac_pkg::ADDR_ROUTE_CTRL, 8'(1 - i));
			@(negedge clk);
			chk({c2a, c2p}, 16'(2 - 2 * i + i));
		end
		$display("config and route test done");
		wr(pwmdac_pkg::ADDR_CODE_LOW_0, 8'h34); wr(pwmdac_pkg::ADDR_CODE_LOW_1, 8'hff);
		wr(pwmdac_pkg::ADDR_CODE_HIGH_0, 8'hbc); wr(pwmdac_pkg::ADDR_CODE_HIGH_1, 8'h2a);
		rd(pwmdac_pkg::ADDR_CODE_LOW_1, 8'h3f);
		wr(pwmdac_pkg::ADDR_ON_0, 8'h03); wr(pwmdac_pkg::ADDR_OFF_0, 8'h02);
		repeat (60) @(negedge clk);
		chk(pos, 16'h0000);
		wr(pwmdac_pkg::ADDR_PULSE_EN, 8'h01);
		repeat (400) @(negedge clk);
		chk(afp, 16'h0001);
		chk(16'(hi_len), 16'h004b);
		chk(16'(lo_len), 16'h0032);
		chk(hi_code, 16'h2abc);
		chk(lo_code, 16'h3f34);
		wait_pin(1'b0); wait_pin(1'b1);
		wr(pwmdac_pkg::ADDR_ON_0, 8'h05);
		wait_pin(1'b0);
		chk(16'(hi_len), 16'h004b);
		repeat (300) @(negedge clk);
		chk(16'(hi_len), 16'h007d);
		$display("pulse timing test done");
		wr(pwmdac_pkg::ADDR_CONV_CTRL, 8'h01);
		repeat (200) @(negedge clk);
		chk({afp, 1'b0, code}, 16'h3f34);
		wait_pin(1'b0);
		wr(pwmdac_pkg::ADDR_PULSE_EN, 8'h00);
		repeat (200) @(negedge clk);
		chk(pos, 16'h0000);
		chk(neg, 16'h0001);
		rd(pwmdac_pkg::ADDR_STATUS, 8'h00);
		// processor reset held two edges, with a code write that it must override
		cpu_rst = 1'b1;
		wr(pwmdac_pkg::ADDR_CODE_LOW_0, 8'h55);
		cpu_rst = 1'b0;
		rd(pwmdac_pkg::ADDR_CODE_LOW_0, 8'h00);
		rd(pwmdac_pkg::ADDR_CODE_HIGH_1, 8'h00);
		chk(code, 16'h0000);
		$display("level and reset test done");
		final_report();
	end
endmodule
